// File: common/cpu_axi_attr_map.vh
// constants for the bus attribute and stream port block
`ifndef CPU_AXI_ATTR_MAP_VH
`define CPU_AXI_ATTR_MAP_VH
`define PROT_INSTR_SECURE    3'h4
`define PROT_INSTR_NONSEC    3'h6
`define PROT_DATA_SECURE     3'h0
`define PROT_DATA_NONSEC     3'h2
`define CACHE_BUFFERABLE     4'h3
`define CACHE_WRITEBACK      4'hf
`define CACHE_NONCACHEABLE   4'h2
`define QOS_PRIO_7           4'h7
`define QOS_PRIO_8           4'h8
`define QOS_PRIO_12          4'hc
`define DOMAIN_INNER         2'h1
`define AXI_ID_WIDTH         0
`define ACE_ID_WIDTH         1
`define NS_BIT_IP            1
`define NS_BIT_DP            0
`define NS_BIT_DC            2
`define NS_BIT_IC            3
`define STREAM_WIDTH         32
`define ADDR_SIZE_DEFAULT    32
`define ADDR_SIZE_MAX        64
`endif

// File: src/cpu_axi_attr_and_stream_ports.v
// bus attribute sidebands and stream put/get ports of the processor core
`timescale 1ns/1ps
`include "cpu_axi_attr_map.vh"
module cpu_axi_attr_and_stream_ports #(
    parameter ADDR_SIZE  = `ADDR_SIZE_DEFAULT,
    parameter PAE_ENABLE = 0,
    parameter DP_FULL    = 1,
    parameter DWIDTH     = 32
) (
    input  wire                   clock,
    input  wire                   nrst,
    input  wire [3:0]             non_secure,
    input  wire                   dc_exclusive,
    input  wire                   dc_dvm,
    input  wire                   ic_dvm,
    input  wire [ADDR_SIZE-1:0]   ic_addr_in,
    input  wire [ADDR_SIZE-1:0]   dc_addr_in,
    output reg  [ADDR_SIZE-1:0]   ic_araddr,
    output reg  [ADDR_SIZE-1:0]   dc_addr,
    output reg  [2:0]             ip_arprot,
    output reg  [3:0]             dp_cache,
    output reg  [2:0]             dp_prot,
    output reg  [3:0]             dp_qos,
    output reg  [3:0]             ic_arcache,
    output reg  [2:0]             ic_arprot,
    output reg  [3:0]             ic_arqos,
    output reg  [1:0]             ic_ardomain,
    output reg  [3:0]             dc_arcache,
    output reg  [3:0]             dc_awcache,
    output reg  [2:0]             dc_prot,
    output reg  [3:0]             dc_arqos,
    output reg  [3:0]             dc_awqos,
    output reg  [1:0]             dc_domain,
    output reg  [2:0]             port_size,
    output reg                    ace_id,
    input  wire                   put_req,
    input  wire                   put_nonblock,
    input  wire                   put_control,
    input  wire [31:0]            put_data,
    output reg                    put_done,
    input  wire                   get_req,
    input  wire                   get_nonblock,
    input  wire                   get_control,
    output reg  [31:0]            get_data,
    output reg                    get_done,
    output reg                    pipeline_stall,
    output reg                    carry_set,
    output reg                    stream_error_flag,
    output reg  [31:0]            m_axis_tdata,
    output reg                    m_axis_tlast,
    output reg                    m_axis_tvalid,
    input  wire                   m_axis_tready,
    input  wire [31:0]            s_axis_tdata,
    input  wire                   s_axis_tlast,
    input  wire                   s_axis_tvalid,
    output reg                    s_axis_tready
);

// ************************************************************
// helper functions
// ************************************************************

// protection pick, shared by every port
// instruction ports set the instruction bit; the select marks non-secure
function [2:0] pick_prot;
    input       instr;
    input       nsec;
    begin
        if (instr)
            pick_prot = nsec ? `PROT_INSTR_NONSEC : `PROT_INSTR_SECURE;
        else
            pick_prot = nsec ? `PROT_DATA_NONSEC : `PROT_DATA_SECURE;
    end
endfunction

// full width transfer size code: log2 of bytes per beat
function [2:0] size_code;
    input integer w;
    begin
        case (w)
            64:      size_code = 3'h3;
            128:     size_code = 3'h4;
            256:     size_code = 3'h5;
            512:     size_code = 3'h6;
            default: size_code = 3'h2;
        endcase
    end
endfunction

// ************************************************************
// transaction id and size
// ************************************************************

// plain ports carry no id wire at all; the coherent ports carry one bit.
// only id zero is ever issued, so the interconnect sees one ordered stream
// and the core never has to reorder responses that come back out of turn
localparam ACE_ID_W = `ACE_ID_WIDTH;

// every beat spans the whole data path: narrow beats would need byte
// lane steering in the interconnect, so the size code is fixed per build
// limitation: a build with a data width other than 64, 128, 256 or 512 falls back to 32

// ************************************************************
// memory mapped attribute sidebands
// ************************************************************

// instruction cache address only widens with address extension
// without extension the upper bits are forced low so a stray high
// address from the core cannot reach memory beyond the 32 bit space
wire [ADDR_SIZE-1:0] ic_addr_masked;
generate
    if (PAE_ENABLE != 0 || ADDR_SIZE == 32) begin : g_ic_wide
        assign ic_addr_masked = ic_addr_in;
    end else begin : g_ic_narrow
        assign ic_addr_masked = {{(ADDR_SIZE-32){1'b0}}, ic_addr_in[31:0]};
    end
endgenerate

// attributes are registered so every output leaves a flip-flop
// the selects are levels from the core, so a change shows one edge later;
// the core must not start a transfer in the cycle in which a select moves
always @(posedge clock) begin
    if (!nrst) begin
        ic_araddr   <= {ADDR_SIZE{1'b0}};
        dc_addr     <= {ADDR_SIZE{1'b0}};
        ip_arprot   <= `PROT_INSTR_SECURE;
        dp_cache    <= 4'h0;
        dp_prot     <= `PROT_DATA_SECURE;
        dp_qos      <= 4'h0;
        ic_arcache  <= `CACHE_WRITEBACK;
        ic_arprot   <= `PROT_INSTR_SECURE;
        ic_arqos    <= `QOS_PRIO_7;
        ic_ardomain <= `DOMAIN_INNER;
        dc_arcache  <= `CACHE_WRITEBACK;
        dc_awcache  <= `CACHE_WRITEBACK;
        dc_prot     <= `PROT_DATA_SECURE;
        dc_arqos    <= `QOS_PRIO_12;
        dc_awqos    <= `QOS_PRIO_8;
        dc_domain   <= `DOMAIN_INNER;
        port_size   <= 3'h2;
        ace_id      <= 1'b0;
    end else begin
        ic_araddr   <= ic_addr_masked;
        dc_addr     <= dc_addr_in;
        ip_arprot   <= pick_prot(1'b1, non_secure[`NS_BIT_IP]);
        dp_cache    <= DP_FULL ? `CACHE_BUFFERABLE : 4'h0;
        dp_prot     <= pick_prot(1'b0, non_secure[`NS_BIT_DP]);
        dp_qos      <= DP_FULL ? `QOS_PRIO_8 : 4'h0;
        ic_arcache  <= ic_dvm ? `CACHE_NONCACHEABLE : `CACHE_WRITEBACK;
        ic_arprot   <= pick_prot(1'b1, non_secure[`NS_BIT_IC]);
        ic_arqos    <= `QOS_PRIO_7;
        ic_ardomain <= `DOMAIN_INNER;
        // dvm only exists on the coherent port; exclusive differs per variant
        if (dc_dvm)
            dc_arcache <= `CACHE_NONCACHEABLE;
        else if (dc_exclusive)
            dc_arcache <= `CACHE_NONCACHEABLE;
        else
            dc_arcache <= `CACHE_WRITEBACK;
        // writes have no dvm form, so only exclusivity picks the write type
        dc_awcache  <= dc_exclusive ? `CACHE_NONCACHEABLE : `CACHE_WRITEBACK;
        dc_prot     <= pick_prot(1'b0, non_secure[`NS_BIT_DC]);
        dc_arqos    <= `QOS_PRIO_12;
        dc_awqos    <= `QOS_PRIO_8;
        dc_domain   <= `DOMAIN_INNER;
        port_size   <= size_code(DWIDTH);
        ace_id      <= {ACE_ID_W{1'b0}};
    end
end

// ************************************************************
// stream put side
// ************************************************************

// busy while a word is offered and not yet taken
wire out_busy = m_axis_tvalid && !m_axis_tready;

// a put is live from the edge it is raised until its done pulse;
// the done pulse masks the request so the core has one cycle to drop it
wire put_live = put_req && !put_done;
// blocking put meeting a busy port holds the pipeline
wire put_wait = put_live && out_busy && !put_nonblock;
// nonblocking put meeting a busy port is refused and flags carry
wire put_skip = put_live && out_busy && put_nonblock;

// the offered word stands until the sink takes it; a new word is only
// loaded when the slot is empty or being emptied in the same edge,
// which keeps one word in flight without any extra buffer
// limitation: a refused nonblocking put leaves the offered word untouched,
// so the sink still receives the older word it was holding
always @(posedge clock) begin
    if (!nrst) begin
        m_axis_tvalid <= 1'b0;
        m_axis_tdata  <= 32'h0;
        m_axis_tlast  <= 1'b0;
        put_done      <= 1'b0;
    end else begin
        // done is a one cycle pulse; the core drops its request on seeing it
        put_done <= 1'b0;
        if (m_axis_tvalid && m_axis_tready)
            m_axis_tvalid <= 1'b0;
        if (put_live) begin
            if (!out_busy) begin
                m_axis_tvalid <= 1'b1;
                m_axis_tdata  <= put_data;
                m_axis_tlast  <= put_control;
                put_done      <= 1'b1;
            end else if (put_nonblock) begin
                put_done <= 1'b1;
            end
        end
    end
end

// ************************************************************
// stream get side
// ************************************************************

// two states: the word is taken in the first cycle and reported in the
// second, matching the two cycle get of the core pipeline; a nonblocking
// get with nothing present ends at once and never touches the input
localparam G_IDLE = 2'b01;
localparam G_DONE = 2'b10;
reg [1:0] gstate_r;

// get side decodes; each is used by exactly one statement
wire get_idle = (gstate_r == G_IDLE);
// blocking get with an empty input holds the pipeline
wire get_wait = get_req && get_idle && !s_axis_tvalid && !get_nonblock;
// the stall is a register, so the core sees it one edge after the
// request; the core holds its request level meanwhile, so nothing is lost

// a get takes the word in its first cycle and ends in the second
always @(posedge clock) begin
    if (!nrst) begin
        gstate_r          <= G_IDLE;
        s_axis_tready     <= 1'b0;
        get_data          <= 32'h0;
        get_done          <= 1'b0;
        carry_set         <= 1'b0;
        stream_error_flag <= 1'b0;
        pipeline_stall    <= 1'b0;
    end else begin
        get_done  <= 1'b0;
        carry_set <= 1'b0;
        pipeline_stall <= put_wait || get_wait;
        if (put_skip)
            carry_set <= 1'b1;
        case (gstate_r)
            G_IDLE: begin
                s_axis_tready <= 1'b0;
                // the error flag keeps its value until the next word is taken
                if (get_req) begin
                    if (s_axis_tvalid) begin
                        s_axis_tready     <= 1'b1;
                        get_data          <= s_axis_tdata;
                        stream_error_flag <= s_axis_tlast ^ get_control;
                        gstate_r          <= G_DONE;
                    end else if (get_nonblock) begin
                        get_done  <= 1'b1;
                        carry_set <= 1'b1;
                    end
                end
            end
            G_DONE: begin
                // tready was a one cycle pulse; it drops here
                s_axis_tready <= 1'b0;
                get_done      <= 1'b1;
                gstate_r      <= G_IDLE;
            end
            default: begin
                s_axis_tready <= 1'b0;
                gstate_r      <= G_IDLE;
            end
        endcase
    end
end

endmodule

// File: test/stream_peer.sv
// stream peer model: sink for the output port, source for the input port
`timescale 1ns/1ps
module stream_peer (
    input wire logic        clock,
    input wire logic        sink_hold,
    input wire logic        src_load,
    input wire logic        src_last,
    input wire logic [31:0] src_word,
    input wire logic        s_axis_tready,
    output logic            m_axis_tready,
    output logic            s_axis_tvalid,
    output logic            s_axis_tlast,
    output logic [31:0]     s_axis_tdata
);
    // *****
    // sink and source
    // *****
    assign m_axis_tready = !sink_hold;
    initial s_axis_tvalid = 1'b0;
    initial s_axis_tlast = 1'b0;
    initial s_axis_tdata = 32'h0;
    // word held until taken, then lines scrambled so stale data never looks valid
    always @(posedge clock) begin
        if (src_load) begin
            s_axis_tvalid <= 1'b1;
            s_axis_tdata  <= src_word;
            s_axis_tlast  <= src_last;
        end else if (s_axis_tvalid && s_axis_tready) begin
            s_axis_tvalid <= 1'b0;
            s_axis_tdata  <= ~s_axis_tdata;
            s_axis_tlast  <= ~s_axis_tlast;
        end
    end
endmodule

// File: test/attr_monitor.sv
// checker for the bus attribute and stream put ports
`timescale 1ns/1ps
module attr_monitor (
    input wire logic       clock,
    input wire logic       nrst,
    input wire logic [3:0] non_secure,
    input wire logic       dc_exclusive,
    input wire logic [2:0] ip_arprot,
    input wire logic [2:0] dp_prot,
    input wire logic [2:0] ic_arprot,
    input wire logic [2:0] dc_prot,
    input wire logic [3:0] dc_awcache,
    input wire logic       put_req,
    input wire logic       put_nonblock,
    input wire logic       put_control,
    input wire logic       put_done,
    input wire logic       carry_set,
    input wire logic       m_axis_tvalid,
    input wire logic       m_axis_tready,
    input wire logic       m_axis_tlast
);
    // *****
    // attribute and put checks
    // *****
    logic [3:0] ns_q;
    logic       ex_q;
    // outputs lag the selects by one edge
    always @(posedge clock) begin
        ns_q <= non_secure;
        ex_q <= dc_exclusive;
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);
    ip_prot_a: assert property ($past(nrst) |-> ip_arprot == (ns_q[1] ? 3'h6 : 3'h4))
        else $error("instr peripheral prot wrong");
    dp_prot_a: assert property ($past(nrst) |-> dp_prot == {1'b0, ns_q[0], 1'b0})
        else $error("data peripheral prot wrong");
    ic_prot_a: assert property ($past(nrst) |-> ic_arprot == {1'b1, ns_q[3], 1'b0})
        else $error("instr cache prot wrong");
    dc_prot_a: assert property ($past(nrst) |-> dc_prot == {1'b0, ns_q[2], 1'b0})
        else $error("data cache prot wrong");
    dc_cache_a: assert property ($past(nrst) |-> dc_awcache == (ex_q ? 4'h2 : 4'hf))
        else $error("data cache write type wrong");
    put_free_a: assert property (put_req && !put_done && !m_axis_tvalid |=>
        put_done && m_axis_tvalid && m_axis_tlast == $past(put_control))
        else $error("free put not sent in one cycle");
    nb_refuse_a: assert property (put_req && put_nonblock && !put_done && m_axis_tvalid
        && !m_axis_tready |=> put_done && carry_set) else $error("busy put not refused");
    word_hold_a: assert property (m_axis_tvalid && !m_axis_tready |=>
        m_axis_tvalid && $stable(m_axis_tlast)) else $error("stream word dropped");
endmodule

// File: test/cpu_axi_attr_and_stream_ports_bench.sv
// testbench for the bus attribute and stream put/get block
`timescale 1ns/1ps
module cpu_axi_attr_and_stream_ports_bench;
    logic clock = 0, nrst = 0, dc_exclusive = 0, dc_dvm = 0, ic_dvm = 0, put_req = 0;
    logic put_nonblock = 0, put_control = 0, get_req = 0, get_nonblock = 0, get_control = 0;
    logic sink_hold = 0, src_load = 0, src_last = 0;
    logic [3:0] non_secure = 0;
    logic [31:0] ic_addr_in = 0, dc_addr_in = 0, put_data = 0, src_word = 0;
    logic [31:0] ic_araddr, dc_addr, get_data, m_axis_tdata, s_axis_tdata;
    logic [2:0] ip_arprot, dp_prot, ic_arprot, dc_prot, port_size;
    logic [3:0] dp_cache, dp_qos, ic_arcache, ic_arqos, dc_arcache, dc_awcache, dc_arqos, dc_awqos;
    logic [1:0] ic_ardomain, dc_domain;
    logic ace_id, put_done, get_done, pipeline_stall, carry_set, stream_error_flag;
    logic m_axis_tlast, m_axis_tvalid, m_axis_tready, s_axis_tlast, s_axis_tvalid, s_axis_tready;
    int n_fail = 0, compares = 0, cyc = 0, n;
    cpu_axi_attr_and_stream_ports uut (.*);
    stream_peer peer (.clock(clock), .sink_hold(sink_hold), .src_load(src_load),
        .src_last(src_last), .src_word(src_word), .s_axis_tready(s_axis_tready),
        .m_axis_tready(m_axis_tready), .s_axis_tvalid(s_axis_tvalid),
        .s_axis_tlast(s_axis_tlast), .s_axis_tdata(s_axis_tdata));
    // *****
    // clock, hang guard and helpers
    // *****
    always #10 clock = ~clock;
    // the whole run needs fewer than a hundred cycles
    always @(posedge clock) begin
        cyc++;
        if (cyc == 2000) begin
            n_fail++;
            close_out();
        end
    end
    task close_out;
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task chk(input logic [63:0] got, input logic [63:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // inputs always move 1 ns after the edge
    task tick;
        @(posedge clock);
        #1;
    endtask
    task load(input logic [31:0] w, input logic l);
        src_word = w;
        src_last = l;
        src_load = 1;
        tick;
        src_load = 0;
    endtask
    task put(input logic nb, input logic c, input logic [31:0] d);
        n = 0;
        tick;
        {put_nonblock, put_control, put_data, put_req} = {nb, c, d, 1'b1};
        tick;
        while (put_done !== 1'b1 && n < 20) begin
            n++;
            tick;
        end
        put_req = 0;
    endtask
    task get(input logic nb, input logic c);
        n = 0;
        tick;
        {get_nonblock, get_control, get_req} = {nb, c, 1'b1};
        tick;
        while (get_done !== 1'b1 && n < 20) begin
            n++;
            tick;
        end
        get_req = 0;
    endtask
    // *****
    // scenarios
    // *****
    task t_attr;
        for (int i = 0; i < 16; i++) begin
            {non_secure, dc_exclusive, dc_dvm, ic_dvm} = {i[3:0], i[0], i[1], i[2]};
            {ic_addr_in, dc_addr_in} = {i[3:0], 28'h0, 28'h0, ~i[3:0]};
            tick;
            tick;
            chk({ip_arprot, dp_prot, ic_arprot, dc_prot}, {(i[1] ? 3'h6 : 3'h4),
                1'b0, i[0], 2'b01, i[3], 2'b00, i[2], 1'b0});
            chk({ic_arcache, dc_arcache}, {(i[2] ? 4'h2 : 4'hf), (i[1:0] != 0 ? 4'h2 : 4'hf)});
            if (!i[1]) chk(dc_awcache, i[0] ? 4'h2 : 4'hf);
            chk({ic_araddr, dc_addr}, {ic_addr_in, dc_addr_in});
        end
        chk({dp_cache, dp_qos, ic_arqos, dc_arqos, dc_awqos, ic_ardomain, dc_domain, port_size},
            {20'h3_87c8, 2'h1, 2'h1, 3'h2});
        chk(ace_id, 1'b0);
        $display("attribute test done");
    endtask
    task t_put;
        put(0, 1, 32'hcafe0001);
        chk({n[7:0], m_axis_tvalid, m_axis_tlast, m_axis_tdata}, {10'h3, 32'hcafe0001});
        tick;
        put(0, 0, 32'h12345678);
        chk({n[7:0], m_axis_tvalid, m_axis_tlast, carry_set}, {8'h0, 3'b100});
        sink_hold = 1;
        put(1, 1, 32'h0000dead);
        chk({n[7:0], carry_set, m_axis_tdata}, {8'h0, 1'b1, 32'h12345678});
        fork
            begin repeat (5) tick; chk(pipeline_stall, 1'b1); sink_hold = 0; end
            put(0, 0, 32'h000055aa);
        join
        chk({n > 3, carry_set, m_axis_tdata}, {2'b10, 32'h000055aa});
        $display("put test done");
    endtask
    task t_get;
        for (int k = 0; k < 4; k++) begin
            load(32'h100 + k, k[0]);
            get(0, k[1]);
            chk({n[7:0], get_data, stream_error_flag}, {8'h1, 32'h100 + k, k[0] ^ k[1]});
        end
        get(1, 0);
        chk({n[7:0], carry_set, get_done}, {8'h0, 2'b11});
        fork
            begin repeat (3) tick; chk(pipeline_stall, 1'b1); load(32'h77, 0); end
            get(0, 0);
        join
        chk({get_data, stream_error_flag, carry_set}, {32'h77, 2'b00});
        $display("get test done");
    endtask
    initial begin
        repeat (5) @(posedge clock);
        #1;
        nrst = 1;
        t_attr;
        t_put;
        t_get;
        close_out;
    end
endmodule
bind cpu_axi_attr_and_stream_ports attr_monitor mon (.*);
